// file: hdl/hss_pkg.sv
// Purpose: Shared constants for the high-side switch control block
// Assumes: 125 MHz clock, APB register access with 32-bit data
// Notes: Offsets are byte addresses of aligned words
package hss_pkg;
   localparam int NUM_OUT = 4;
   localparam int CLK_MHZ = 125;
   // Filter times in microseconds
   localparam int OC_FILT_US = 16;
   localparam int OL_FILT_US = 220;
   localparam int OC_FILT_CYC = OC_FILT_US * CLK_MHZ;
   localparam int OL_FILT_CYC = OL_FILT_US * CLK_MHZ;
   localparam int FILT_W = 16;
   // Source selector codes
   localparam logic [3:0] SRC_OFF = 4'h0;
   localparam logic [3:0] SRC_ON = 4'h1;
   localparam logic [3:0] SRC_TMR1 = 4'h2;
   localparam logic [3:0] SRC_TMR2 = 4'h3;
   localparam logic [3:0] SRC_GEN1 = 4'h4;
   localparam logic [3:0] SRC_GEN4 = 4'h7;
   localparam logic [3:0] SRC_SYNC = 4'h8;
   // Wake pin function select codes
   localparam logic [1:0] WK_FN_SYNC = 2'h2;
   // Device mode codes
   localparam logic [2:0] MODE_NORMAL = 3'h0;
   localparam logic [2:0] MODE_STOP = 3'h1;
   localparam logic [2:0] MODE_SLEEP = 3'h2;
   localparam logic [2:0] MODE_RESTART = 3'h3;
   localparam logic [2:0] MODE_FAILSAFE = 3'h4;
   // Register offsets
   localparam logic [7:0] OFS_SRC = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_GEN0 = 8'h08;
   localparam logic [7:0] OFS_TMR0 = 8'h18;
   localparam logic [7:0] OFS_CFG = 8'h20;
   // Field positions
   localparam int STAT_OL_POS = 4;
   localparam int STAT_UV_POS = 8;
   localparam int GEN_FSEL_POS = 16;
   localparam int TMR_DUTY_POS = 16;
   localparam int CFG_UVSD_POS = 0;
   localparam int CFG_UVREC_POS = 1;
   localparam int CFG_LPOV_POS = 2;
   localparam int CFG_WKFN_POS = 4;
   localparam int CFG_SYNC_POS = 8;
   // Generator period selections, one less than the clock cycles per duty step
   localparam logic [7:0] GEN_DIV_SLOW = 8'h3f;
   localparam logic [7:0] GEN_DIV_FAST = 8'h0f;
   localparam logic [9:0] GEN_TOP = 10'h3ff;
   // Timer tick prescale, one tick per millisecond
   localparam logic [16:0] TMR_PRE = 17'h1e847;
endpackage

// file: hdl/hss_pulse_gen.sv
// Purpose: One internal 10-bit PWM generator
// Assumes: Single clock domain
// Notes: Two base frequencies from a step divider
`timescale 1ns/100ps
`default_nettype none
module hss_pulse_gen (
   input wire logic clk,
   input wire logic rst,
   input wire logic [9:0] duty,
   input wire logic fsel,
   output logic pwm_out
);
   typedef struct packed {
      logic [7:0] div;
      logic [9:0] cnt;
      logic out;
   } hss_gen_st_t;
   hss_gen_st_t s_q, s_d;

   // Step divider then 10-bit counter compare
   always_comb begin
      s_d = s_q;
      if (s_q.div == (fsel ? hss_pkg::GEN_DIV_FAST : hss_pkg::GEN_DIV_SLOW)) begin // [R14]
         s_d.div = 8'h00;
         s_d.cnt = (s_q.cnt == hss_pkg::GEN_TOP) ? 10'h000 : s_q.cnt + 10'h001;
      end else begin
         s_d.div = s_q.div + 8'h01;
      end
      s_d.out = (s_q.cnt < duty); // [R13] tiny duty gives a pulse the switch cannot follow [R17]
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign pwm_out = s_q.out;
endmodule
`default_nettype wire

// file: hdl/hss_ctrl.sv
// Purpose: High-side switch control with fault handling and drive sources
// Assumes: Analogue comparators give level inputs, synchronised here
// Notes: APB slave, zero wait states
// How it works
// [R1] Overcurrent past filter time switches output off
// [R2] Overcurrent sets flag, source field set off
// [R3] Software re-enables by writing on or timer
// [R4] Software clears overcurrent flag before reactivating
// [R5] Overcurrent flags stay until software clears
// [R6] Open load checked only while output on
// [R7] Open load only flags, never shuts down
// [R8] Open-load flags sticky, cleared by software only
// [R9] Open load must persist filter time first
// [R10] Per-output source selector with nine choices
// [R11] Static selections hold in normal, stop, sleep
// [R12] Two timers, independent period and duty
// [R13] Generators take independent 10-bit duty
// [R14] Each generator selects one of two frequencies
// [R15] Software programs generator before assigning it
// [R16] Waveform starts as soon as assigned
// [R17] One-LSB duty too short for switch
// [R18] Wake pin in sync mode loses wake
// [R19] Sync code allowed only after pin set
// [R20] Sync pin drives one dedicated output directly
// [R21] Undervoltage switches off unless disabled, flag only; the code sets no flag when shutdown is disabled
// [R22] After undervoltage restore or clear per recovery
// [R23] Low-power overvoltage keeps outputs only if disabled
// [R24] Restart or fail-safe disables all outputs
// [R25] Sync pin passes two flip-flops
// [R26] Flag clears touch only addressed bits
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module hss_ctrl (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [3:0] oc_detect,
   input wire logic [3:0] ol_detect,
   input wire logic uv_detect,
   input wire logic ov_detect,
   input wire logic [2:0] device_mode,
   input wire logic wake_input_four,
   output logic [3:0] switch_output_n,
   output logic wake_enable_four
);
   localparam int N = hss_pkg::NUM_OUT;

   typedef struct packed {
      logic [N-1:0][3:0] src;
      logic [N-1:0] overcurrent_flag;
      logic [N-1:0] open_load_flag;
      logic uv_flag;
      logic uv_active;
      logic [N-1:0][9:0] gen_duty;
      logic [N-1:0] gen_fsel;
      logic [1:0][15:0] tmr_per;
      logic [1:0][15:0] tmr_duty;
      logic [1:0][15:0] tmr_cnt;
      logic [16:0] tmr_pre;
      logic uv_shutdown_disable;
      logic uv_recovery_enable;
      logic lowpower_ov_shutdown_disable;
      logic [1:0] wake_pin_function_select;
      logic [1:0] sync_target;
      logic [N-1:0][hss_pkg::FILT_W-1:0] oc_cnt;
      logic [N-1:0][hss_pkg::FILT_W-1:0] ol_cnt;
      logic [1:0] wk_sync;
      logic [N-1:0][1:0] oc_sync;
      logic [N-1:0][1:0] ol_sync;
      logic [1:0] uv_sync;
      logic [1:0] ov_sync;
      logic [N-1:0] out;
   } hss_st_t;
   hss_st_t s_q, s_d;

   logic [N-1:0] gen_out;
   logic [N-1:0] drive;
   logic wr_en;
   logic rd_en;
   logic tmr_tick;

   // Internal generators, one per slot
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : gen_pwm
         hss_pulse_gen u_gen (
            .clk(clk),
            .rst(rst),
            .duty(s_q.gen_duty[g]),
            .fsel(s_q.gen_fsel[g]),
            .pwm_out(gen_out[g])
         );
      end
   endgenerate

   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign tmr_tick = (s_q.tmr_pre == hss_pkg::TMR_PRE);
   assign pready = 1'b1;
   // Wake capability withdrawn while the pin serves as sync input
   assign wake_enable_four = (s_q.wake_pin_function_select != hss_pkg::WK_FN_SYNC); // [R18]

   // Source decode for each output
   always_comb begin
      for (int i = 0; i < N; i++) begin
         unique case (s_q.src[i])
            hss_pkg::SRC_OFF: drive[i] = 1'b0;
            hss_pkg::SRC_ON: drive[i] = 1'b1; // [R11]
            hss_pkg::SRC_TMR1: drive[i] = s_q.tmr_cnt[0] < s_q.tmr_duty[0]; // [R12]
            hss_pkg::SRC_TMR2: drive[i] = s_q.tmr_cnt[1] < s_q.tmr_duty[1];
            hss_pkg::SRC_SYNC: drive[i] = s_q.wk_sync[1] && (s_q.sync_target == 2'(i)) &&
               (s_q.wake_pin_function_select == hss_pkg::WK_FN_SYNC); // [R19] [R20]
            default: drive[i] = (s_q.src[i] >= hss_pkg::SRC_GEN1 && s_q.src[i] <= hss_pkg::SRC_GEN4) ?
               gen_out[s_q.src[i][1:0]] : 1'b0; // [R10] [R16]
         endcase
      end
   end

   // Read mux, unmapped reads answer zero with an error
   always_comb begin
      prdata = 32'h0000_0000;
      pslverr = 1'b0;
      if (paddr == hss_pkg::OFS_SRC) begin
         for (int i = 0; i < N; i++) begin
            prdata[4*i +: 4] = s_q.src[i];
         end
      end else if (paddr == hss_pkg::OFS_STAT) begin
         prdata[N-1:0] = s_q.overcurrent_flag;
         prdata[hss_pkg::STAT_OL_POS +: N] = s_q.open_load_flag;
         prdata[hss_pkg::STAT_UV_POS] = s_q.uv_flag;
      end else if (paddr >= hss_pkg::OFS_GEN0 && paddr < hss_pkg::OFS_TMR0 && paddr[1:0] == 2'h0) begin
         prdata[9:0] = s_q.gen_duty[2'(paddr[7:2] - 6'h02)];
         prdata[hss_pkg::GEN_FSEL_POS] = s_q.gen_fsel[2'(paddr[7:2] - 6'h02)];
      end else if (paddr >= hss_pkg::OFS_TMR0 && paddr < hss_pkg::OFS_CFG && paddr[1:0] == 2'h0) begin
         prdata[15:0] = s_q.tmr_per[paddr[2]];
         prdata[hss_pkg::TMR_DUTY_POS +: 16] = s_q.tmr_duty[paddr[2]];
      end else if (paddr == hss_pkg::OFS_CFG) begin
         prdata[hss_pkg::CFG_UVSD_POS] = s_q.uv_shutdown_disable;
         prdata[hss_pkg::CFG_UVREC_POS] = s_q.uv_recovery_enable;
         prdata[hss_pkg::CFG_LPOV_POS] = s_q.lowpower_ov_shutdown_disable;
         prdata[hss_pkg::CFG_WKFN_POS +: 2] = s_q.wake_pin_function_select;
         prdata[hss_pkg::CFG_SYNC_POS +: 2] = s_q.sync_target;
      end else begin
         pslverr = psel & penable;
      end
      if (!rd_en) begin
         prdata = 32'h0000_0000;
      end
   end

   // Next-state logic: bus writes first, hardware events override
   always_comb begin
      logic lowpower;
      logic kill_all;
      lowpower = 1'b0;
      kill_all = 1'b0;
      s_d = s_q;
      // Two-stage synchronisers for every asynchronous input
      s_d.wk_sync = {s_q.wk_sync[0], wake_input_four}; // [R25]
      s_d.uv_sync = {s_q.uv_sync[0], uv_detect};
      s_d.ov_sync = {s_q.ov_sync[0], ov_detect};
      for (int i = 0; i < N; i++) begin
         s_d.oc_sync[i] = {s_q.oc_sync[i][0], oc_detect[i]};
         s_d.ol_sync[i] = {s_q.ol_sync[i][0], ol_detect[i]};
      end
      // Timers, period counted in prescaled ticks
      s_d.tmr_pre = tmr_tick ? 17'h00000 : s_q.tmr_pre + 17'h00001;
      for (int t = 0; t < 2; t++) begin
         if (tmr_tick) begin
            s_d.tmr_cnt[t] = (s_q.tmr_cnt[t] >= s_q.tmr_per[t]) ? 16'h0000 : s_q.tmr_cnt[t] + 16'h0001;
         end
      end
      // Register writes, full-word only when all lanes strobed
      if (wr_en && pstrb == 4'hf) begin
         if (paddr == hss_pkg::OFS_SRC) begin
            for (int i = 0; i < N; i++) begin
               s_d.src[i] = pwdata[4*i +: 4]; // [R3] [R15]
            end
         end else if (paddr == hss_pkg::OFS_STAT) begin
            // Write one to clear only the addressed flags
            s_d.overcurrent_flag = s_q.overcurrent_flag & ~pwdata[N-1:0]; // [R26] [R4]
            s_d.open_load_flag = s_q.open_load_flag & ~pwdata[hss_pkg::STAT_OL_POS +: N]; // [R26] [R8]
            if (pwdata[hss_pkg::STAT_UV_POS]) begin
               s_d.uv_flag = 1'b0;
            end
         end else if (paddr >= hss_pkg::OFS_GEN0 && paddr < hss_pkg::OFS_TMR0 && paddr[1:0] == 2'h0) begin
            s_d.gen_duty[2'(paddr[7:2] - 6'h02)] = pwdata[9:0]; // [R13]
            s_d.gen_fsel[2'(paddr[7:2] - 6'h02)] = pwdata[hss_pkg::GEN_FSEL_POS]; // [R14]
         end else if (paddr >= hss_pkg::OFS_TMR0 && paddr < hss_pkg::OFS_CFG && paddr[1:0] == 2'h0) begin
            s_d.tmr_per[paddr[2]] = pwdata[15:0]; // [R12]
            s_d.tmr_duty[paddr[2]] = pwdata[hss_pkg::TMR_DUTY_POS +: 16];
         end else if (paddr == hss_pkg::OFS_CFG) begin
            s_d.uv_shutdown_disable = pwdata[hss_pkg::CFG_UVSD_POS];
            s_d.uv_recovery_enable = pwdata[hss_pkg::CFG_UVREC_POS];
            s_d.lowpower_ov_shutdown_disable = pwdata[hss_pkg::CFG_LPOV_POS];
            s_d.wake_pin_function_select = pwdata[hss_pkg::CFG_WKFN_POS +: 2];
            s_d.sync_target = pwdata[hss_pkg::CFG_SYNC_POS +: 2];
         end
      end
      // Undervoltage: switch off and flag unless disabled, recover or clear on release
      if (s_q.uv_sync[1] && !s_q.uv_shutdown_disable) begin
         s_d.uv_active = 1'b1; // [R21]
         s_d.uv_flag = 1'b1;
      end else if (s_q.uv_active) begin
         s_d.uv_active = 1'b0;
         if (!s_q.uv_recovery_enable) begin
            for (int i = 0; i < N; i++) begin
               s_d.src[i] = hss_pkg::SRC_OFF; // [R22]
            end
         end
      end
      lowpower = (device_mode == hss_pkg::MODE_STOP) || (device_mode == hss_pkg::MODE_SLEEP);
      kill_all = s_q.uv_active ||
         (device_mode == hss_pkg::MODE_RESTART) || (device_mode == hss_pkg::MODE_FAILSAFE) || // [R24]
         (lowpower && s_q.ov_sync[1] && !s_q.lowpower_ov_shutdown_disable); // [R23]
      for (int i = 0; i < N; i++) begin
         // Overcurrent filter counts only while the output conducts
         if (s_q.out[i] && s_q.oc_sync[i][1]) begin
            s_d.oc_cnt[i] = s_q.oc_cnt[i] + 16'h0001;
         end else begin
            s_d.oc_cnt[i] = '0;
         end
         if (s_q.oc_cnt[i] >= hss_pkg::FILT_W'(hss_pkg::OC_FILT_CYC)) begin // [R1]
            s_d.overcurrent_flag[i] = 1'b1; // [R2] [R5] set beats clear
            s_d.src[i] = hss_pkg::SRC_OFF; // [R2]
            s_d.oc_cnt[i] = '0;
         end
         // Open load judged only during on state; no shutdown
         if (s_q.out[i] && s_q.ol_sync[i][1]) begin // [R6]
            if (s_q.ol_cnt[i] >= hss_pkg::FILT_W'(hss_pkg::OL_FILT_CYC)) begin // [R9]
               s_d.open_load_flag[i] = 1'b1; // [R7] [R8]
            end else begin
               s_d.ol_cnt[i] = s_q.ol_cnt[i] + 16'h0001;
            end
         end else begin
            s_d.ol_cnt[i] = '0;
         end
         s_d.out[i] = drive[i] && !kill_all && (s_d.src[i] != hss_pkg::SRC_OFF);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
   assign switch_output_n = s_q.out;
endmodule
`default_nettype wire

// file: verification/hss_ctrl_sva.sv
// Purpose: Port checks for hss_ctrl
// Assumes: Config is snooped from APB writes
// Notes: Device-side field rewrites make the snoop stale
`timescale 1ns/100ps
`default_nettype none
module hss_ctrl_sva (
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pslverr,
   input wire logic [3:0] oc_detect,
   input wire logic uv_detect,
   input wire logic ov_detect,
   input wire logic [2:0] device_mode,
   input wire logic wake_input_four,
   input wire logic [3:0] switch_output_n,
   input wire logic wake_enable_four
);
   localparam int OC_LIM = hss_pkg::OC_FILT_CYC + 6;
   localparam int OC_MIN = 12 * hss_pkg::CLK_MHZ;
   logic [31:0] src_q;
   logic [31:0] cfg_q;
   logic stale_q;
   logic [15:0] oc_cnt_q;
   logic wr;
   logic sync_on;
   logic [1:0] tgt;
   assign wr = psel && penable && pwrite && pstrb == 4'hf;
   assign tgt = cfg_q[9:8];
   assign sync_on = cfg_q[5:4] == hss_pkg::WK_FN_SYNC && src_q[{tgt, 2'b00} +: 4] == hss_pkg::SRC_SYNC && !stale_q;
   // Shadow config; stale while the device may rewrite fields itself
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         src_q <= '0;
         cfg_q <= '0;
         stale_q <= 1'b0;
         oc_cnt_q <= '0;
      end else begin
         if (wr && paddr == hss_pkg::OFS_SRC) begin
            src_q <= pwdata;
         end
         if (wr && paddr == hss_pkg::OFS_CFG) begin
            cfg_q <= pwdata;
         end
         stale_q <= (stale_q && !(wr && paddr == hss_pkg::OFS_SRC)) || uv_detect || ov_detect || (|oc_detect)
            || device_mode > hss_pkg::MODE_SLEEP;
         oc_cnt_q <= oc_detect[0] ? oc_cnt_q + 16'h1 : 16'h0;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence st_on_s;
      (src_q[3:0] == hss_pkg::SRC_ON && !stale_q)[*4];
   endsequence
   sequence pin_low_s;
      (sync_on && !wake_input_four)[*5];
   endsequence
   property follow_p(bit v);
      (sync_on && wake_input_four == v)[*5] |-> switch_output_n[tgt] == v;
   endproperty
   unmapped_err_a: assert property (psel && penable && paddr > hss_pkg::OFS_CFG |-> pslverr) else $error("no slverr");
   oc_late_a: assert property (switch_output_n[0] |-> oc_cnt_q <= OC_LIM) else $error("oc late");
   // Load current vanishes with the switch, so look one cycle back
   oc_early_a: assert property ($fell(switch_output_n[0]) && $past(oc_detect[0]) |-> oc_cnt_q >= OC_MIN)
      else $error("oc early");
   halt_modes_a: assert property ((device_mode >= hss_pkg::MODE_RESTART)[*2] |-> switch_output_n == 4'h0)
      else $error("on in halt mode");
   static_on_a: assert property (st_on_s |-> switch_output_n[0]) else $error("static on lost");
   uv_off_a: assert property ((uv_detect && !cfg_q[0])[*6] |-> switch_output_n == 4'h0) else $error("uv on");
   sync_nowake_a: assert property ((cfg_q[5:4] == hss_pkg::WK_FN_SYNC)[*2] |-> !wake_enable_four)
      else $error("wake kept");
   sync_high_a: assert property (follow_p(1'b1)) else $error("sync high");
   sync_low_a: assert property (follow_p(1'b0)) else $error("sync low");
   sync_two_ff_a: assert property (pin_low_s ##1 (sync_on && wake_input_four) |=> !switch_output_n[tgt])
      else $error("sync too fast");
endmodule
bind hss_ctrl hss_ctrl_sva u_sva (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pslverr,
   .oc_detect, .uv_detect, .ov_detect, .device_mode, .wake_input_four, .switch_output_n, .wake_enable_four);
`default_nettype wire

// file: verification/hss_load_model.sv
// Purpose: Resistive loads on four outputs
// Assumes: Bench commands short or open per output
// Notes: An off switch draws nothing, so it reads as open
`timescale 1ns/100ps
`default_nettype none
module hss_load_model (
   input wire logic [3:0] sw,
   input wire logic [3:0] short_cmd,
   input wire logic [3:0] open_cmd,
   output logic [3:0] oc_detect,
   output logic [3:0] ol_detect
);
   // Overcurrent only through a closed switch
   assign oc_detect = sw & short_cmd;
   // No current when off, so the comparator reports open
   assign ol_detect = ~sw | open_cmd;
endmodule
`default_nettype wire

// file: verification/high_side_switch_control_tb.sv
// Purpose: Self-checking bench for hss_ctrl
// Assumes: Zero-wait APB slave, load model on outputs
// Notes: Checks read values settled at the previous edge
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module high_side_switch_control_tb;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [31:0] x; logic e;} hss_row_t;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, uv_detect, ov_detect;
   logic wake_input_four, wake_enable_four, er;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb, oc_detect, ol_detect, switch_output_n, short_cmd, open_cmd;
   logic [2:0] device_mode;
   int error_cnt = 0;
   int n_compared = 0;
   int ton;
   // Partial strobe and unmapped rows expect refusal
   hss_row_t rows [5] = '{'{8'h00, 32'h0000_1111, 4'h3, 32'h0, 1'b0}, '{8'h08, 32'h0001_03ff, 4'hf, 32'h0001_03ff, 1'b0},
      '{8'h1c, 32'h0005_000a, 4'hf, 32'h0005_000a, 1'b0}, '{8'h20, 32'h6, 4'hf, 32'h6, 1'b0},
      '{8'h24, 32'h1234_5678, 4'hf, 32'h0, 1'b1}};
   hss_ctrl u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .oc_detect, .ol_detect, .uv_detect, .ov_detect, .device_mode, .wake_input_four, .switch_output_n,
      .wake_enable_four);
   hss_load_model u_load (.sw(switch_output_n), .short_cmd, .open_cmd, .oc_detect, .ol_detect);
   // Setup then access; held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'hf);
   endtask
   task automatic rdr(input logic [7:0] a);
      apb(1'b0, a, 32'h0, 4'h0);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic end_of_test();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Hang guard, well past the longest sequence
   initial begin
      #(8 * 60000);
      error_cnt++;
      end_of_test();
   end
   initial begin
      // Sync pin starts low so its first rise under sync drive is seen
      {rst, psel, penable, pwrite, uv_detect, ov_detect, wake_input_four} = 7'h40;
      {paddr, pwdata, pstrb, device_mode, short_cmd, open_cmd} = '0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      `CHK({switch_output_n, wake_enable_four}, 5'h01)
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d, rows[i].s);
         `CHK(er, rows[i].e)
         rdr(rows[i].a);
         `CHK(rd, rows[i].x)
      end
      wr(8'h00, 32'h1111);
      for (int m = 0; m < 5; m++) begin
         device_mode <= 3'(m);
         cyc(4);
         `CHK(switch_output_n, (m < 3) ? 4'hf : 4'h0)
      end
      // Overvoltage in stop mode, with and without keep-on
      for (int k = 0; k < 2; k++) begin
         device_mode <= hss_pkg::MODE_NORMAL;
         ov_detect <= 1'b0;
         wr(8'h20, k ? 32'h4 : 32'h0);
         wr(8'h00, 32'h1111);
         device_mode <= hss_pkg::MODE_STOP;
         ov_detect <= 1'b1;
         cyc(8);
         `CHK(switch_output_n, k ? 4'hf : 4'h0)
      end
      device_mode <= hss_pkg::MODE_NORMAL;
      ov_detect <= 1'b0;
      wr(8'h00, 32'h1111);
      // Short on output 0, open on output 1
      short_cmd <= 4'h1;
      open_cmd <= 4'h2;
      cyc(1500);
      `CHK(switch_output_n[0], 1'b1)
      cyc(600);
      `CHK(switch_output_n, 4'he)
      rdr(8'h00);
      `CHK(rd[15:0], 16'h1110)
      rdr(8'h04);
      `CHK(rd[8:0], 9'h001)
      cyc(17300);
      rdr(8'h04);
      `CHK(rd[8:0], 9'h001)
      cyc(8200);
      rdr(8'h04);
      `CHK({rd[8:0], switch_output_n[1]}, 10'h043)
      short_cmd <= 4'h0;
      open_cmd <= 4'h0;
      cyc(4);
      rdr(8'h04);
      `CHK(rd[8:0], 9'h021)
      wr(8'h04, 32'h1);
      rdr(8'h04);
      `CHK(rd[8:0], 9'h020)
      wr(8'h04, 32'h20);
      rdr(8'h04);
      `CHK(rd[8:0], 9'h000)
      wr(8'h00, 32'h1111);
      cyc(3);
      `CHK(switch_output_n, 4'hf)
      // Undervoltage: recovery, no recovery, shutdown disabled
      for (int k = 0; k < 3; k++) begin
         wr(8'h20, (k == 0) ? 32'h2 : 32'(k - 1));
         wr(8'h00, 32'h1111);
         uv_detect <= 1'b1;
         cyc(8);
         `CHK(switch_output_n, (k == 2) ? 4'hf : 4'h0)
         rdr(8'h04);
         if (k < 2) begin
            `CHK(rd[8:0], 9'h100)
         end
         uv_detect <= 1'b0;
         cyc(8);
         `CHK(switch_output_n, (k == 1) ? 4'h0 : 4'hf)
         rdr(8'h00);
         `CHK(rd[15:0], (k == 1) ? 16'h0 : 16'h1111)
         wr(8'h04, 32'h100);
      end
      // Half duty, fast step: one period of 1024 x 16 cycles
      wr(8'h08, 32'h0001_0200);
      wr(8'h00, 32'h4);
      ton = 0;
      repeat (16384) begin
         @(posedge clk);
         ton += int'(switch_output_n[0]);
      end
      `CHK(ton > 8100 && ton < 8300, 1'b1)
      wr(8'h20, 32'h320);
      wr(8'h00, 32'h8000);
      cyc(6);
      `CHK(wake_enable_four, 1'b0)
      wake_input_four <= 1'b1;
      cyc(6);
      `CHK(switch_output_n, 4'h8)
      wake_input_four <= 1'b0;
      cyc(6);
      `CHK(switch_output_n, 4'h0)
      end_of_test();
   end
endmodule
`default_nettype wire
